// ---- core/fphsu_params.svh ----
// constants for the fp and half-word store unit: opcode patterns and field positions
// assumes 32-bit instruction words, primary opcode in the top six bits
`ifndef FPHSU_PARAMS_SVH
`define FPHSU_PARAMS_SVH
`define FPHSU_PRIMARY_LSB 26
`define FPHSU_SRC_LSB 21
`define FPHSU_BASE_LSB 16
`define FPHSU_INDEX_LSB 11
`define FPHSU_XO_LSB 1
`define FPHSU_DISP_LSB 0
`define FPHSU_PRIMARY_X 6'h1F
`define FPHSU_PRIMARY_STFS 6'h34
`define FPHSU_PRIMARY_STFSU 6'h35
`define FPHSU_PRIMARY_STH 6'h2C
`define FPHSU_PRIMARY_STHU 6'h2D
`define FPHSU_XO_STFDX 10'h2D7
`define FPHSU_XO_STFIWX 10'h3D7
`define FPHSU_XO_STFSUX 10'h2B7
`define FPHSU_XO_STFSX 10'h297
`define FPHSU_XO_STHBRX 10'h396
`define FPHSU_XO_STHUX 10'h1B7
`define FPHSU_SIZE_HALF 4'h2
`define FPHSU_SIZE_WORD 4'h4
`define FPHSU_SIZE_DOUBLE 4'h8
`endif

// ---- core/fphsu_pkg.sv ----
// types for the fp and half-word store unit
// assumes the params header is on the include path
package fphsu_pkg;
	typedef enum logic [1:0] {fphsu_data_fp_double, fphsu_data_fp_raw32, fphsu_data_fp_single,
		fphsu_data_half} fphsu_data_type;
	typedef enum logic [1:0] {fphsu_st_idle, fphsu_st_issue, fphsu_st_wait} fphsu_state_type;
endpackage : fphsu_pkg

// ---- core/fphsu_single_conv.sv ----
// double to single-precision store conversion, combinational
// assumes the operand is already representable as single (software's job)
`timescale 1ns/1ns
`default_nettype none
module fphsu_single_conv (
	input wire logic [63:0] double_in, // fp register contents
	output logic [31:0] single_out // stored word
);
	wire logic [10:0] exp_field;
	wire logic big_exp;
	wire logic [31:0] denorm_word;
	wire logic [5:0] shift_amount;
	wire logic [52:0] mant_full;
	assign exp_field = double_in[62:52];
	// exponents above 896 or equal to zero keep the plain high/low bit pick; other lower ones denormalise
	assign big_exp = (exp_field > 11'h380) || (exp_field == 11'h000);
	assign mant_full = {1'b1, double_in[51:0]};
	assign shift_amount = (exp_field > 11'h36A) ? 6'(11'h381 - exp_field) : 6'h17;
	// denormal result: shift the implied-one mantissa right, no rounding
	assign denorm_word = {double_in[63], 8'h00, 23'((mant_full >> 29) >> shift_amount)};
	assign single_out = big_exp ? {double_in[63:62], double_in[58:29]} : denorm_word;
endmodule : fphsu_single_conv
`default_nettype wire

// ---- core/fphsu_store_unit.sv ----
// fp and half-word store decode and execute: address, data format, base update
// assumes register files answer reads combinationally and memory accepts with mem_ready_in
`timescale 1ns/1ns
`default_nettype none
`include "fphsu_params.svh"
// Functional notes
// - indexed fp double store writes all 64 bits
// - fp-as-integer store writes low word unconverted
// - integer store after single result undefined
// - single store: base-or-zero plus displacement, converted
// - single update: base plus displacement, write back
// - single update indexed: base plus index, write back
// - single indexed: base-or-zero plus index, converted
// - update forms write address into base
// - update form with base zero is invalid
// - half store: base-or-zero plus sign-extended displacement
// - half stores take only low 16 bits
// - byte-reversed half store swaps the two bytes
// - half update: base plus displacement, write back
// - half update indexed: base plus index, write back
module fphsu_store_unit (
	input wire logic clk_in, // core clock, 50 MHz
	input wire logic reset_in, // synchronous reset, high
	input wire logic issue_valid_in, // instruction offered
	input wire logic [31:0] instr_in, // instruction word
	output logic issue_ready_out, // unit can take an instruction
	output logic [4:0] gpr_addr_a_out, // base register read index
	input wire logic [63:0] gpr_data_a_in, // base register value
	output logic [4:0] gpr_addr_b_out, // index register index
	input wire logic [63:0] gpr_data_b_in, // index register value
	output logic [4:0] gpr_addr_s_out, // store source register index
	input wire logic [63:0] gpr_data_s_in, // store source value
	output logic [4:0] fpr_addr_out, // fp source register index
	input wire logic [63:0] fpr_data_in, // fp source value
	output logic mem_valid_out, // store request
	input wire logic mem_ready_in, // memory accepts request
	output logic [63:0] mem_addr_out, // effective address
	output logic [63:0] mem_data_out, // store data, right aligned
	output logic [3:0] mem_size_out, // bytes stored
	output logic wb_valid_out, // base register write pulse
	output logic [4:0] wb_addr_out, // base register written
	output logic [63:0] wb_data_out, // effective address written back
	output logic invalid_form_out, // pulse: update with base zero
	output logic unknown_instr_out // pulse: not a store of this group
);
	import fphsu_pkg::*;
	// instruction fields
	wire logic [5:0] primary;
	wire logic [9:0] ext_op;
	wire logic [4:0] src_field;
	wire logic [4:0] base_field;
	wire logic [4:0] index_field;
	wire logic [15:0] disp;
	assign primary = instr_in[`FPHSU_PRIMARY_LSB +: 6];
	assign src_field = instr_in[`FPHSU_SRC_LSB +: 5];
	assign base_field = instr_in[`FPHSU_BASE_LSB +: 5];
	assign index_field = instr_in[`FPHSU_INDEX_LSB +: 5];
	assign ext_op = instr_in[`FPHSU_XO_LSB +: 10];
	assign disp = instr_in[`FPHSU_DISP_LSB +: 16];
	// decode, by primary then extended opcode
	wire logic is_x;
	wire logic op_stfdx;
	wire logic op_stfiwx;
	wire logic op_stfs;
	wire logic op_stfsu;
	wire logic op_stfsux;
	wire logic op_stfsx;
	wire logic op_sth;
	wire logic op_sthbrx;
	wire logic op_sthu;
	wire logic op_sthux;
	assign is_x = primary == `FPHSU_PRIMARY_X;
	assign op_stfdx = is_x && ext_op == `FPHSU_XO_STFDX;
	assign op_stfiwx = is_x && ext_op == `FPHSU_XO_STFIWX;
	assign op_stfsux = is_x && ext_op == `FPHSU_XO_STFSUX;
	assign op_stfsx = is_x && ext_op == `FPHSU_XO_STFSX;
	assign op_sthbrx = is_x && ext_op == `FPHSU_XO_STHBRX;
	assign op_sthux = is_x && ext_op == `FPHSU_XO_STHUX;
	assign op_stfs = primary == `FPHSU_PRIMARY_STFS;
	assign op_stfsu = primary == `FPHSU_PRIMARY_STFSU;
	assign op_sth = primary == `FPHSU_PRIMARY_STH;
	assign op_sthu = primary == `FPHSU_PRIMARY_STHU;
	// form classes
	wire logic known;
	wire logic is_update;
	wire logic is_indexed;
	wire logic is_fp;
	wire logic is_invalid;
	assign known = op_stfdx | op_stfiwx | op_stfs | op_stfsu | op_stfsux | op_stfsx
		| op_sth | op_sthbrx | op_sthu | op_sthux;
	assign is_update = op_stfsu | op_stfsux | op_sthu | op_sthux;
	assign is_indexed = op_stfdx | op_stfiwx | op_stfsux | op_stfsx | op_sthbrx | op_sthux;
	assign is_fp = op_stfdx | op_stfiwx | op_stfs | op_stfsu | op_stfsux | op_stfsx;
	assign is_invalid = is_update && base_field == 5'h00;
	// register file reads are driven straight from the instruction offered
	assign gpr_addr_a_out = base_field;
	assign gpr_addr_b_out = index_field;
	assign gpr_addr_s_out = src_field;
	assign fpr_addr_out = src_field;
	// address formation
	function automatic logic [63:0] fphsu_sign_extend(input logic [15:0] value);
		fphsu_sign_extend = {{48{value[15]}}, value};
	endfunction : fphsu_sign_extend
	wire logic [63:0] base_value;
	wire logic [63:0] offset_value;
	wire logic [63:0] effective_address;
	// zero substitution only for non-update forms; update forms with zero are refused anyway
	assign base_value = (!is_update && base_field == 5'h00) ? 64'h0 : gpr_data_a_in;
	assign offset_value = is_indexed ? gpr_data_b_in : fphsu_sign_extend(disp);
	assign effective_address = base_value + offset_value;
	// data selection
	wire logic [31:0] single_word;
	wire logic [15:0] half_data;
	wire logic [63:0] store_data;
	wire logic [3:0] store_size;
	fphsu_single_conv conv (
		.double_in(fpr_data_in),
		.single_out(single_word)
	);
	// low 16 bits only; reversed form puts the lowest byte first in memory order
	assign half_data = op_sthbrx ? {gpr_data_s_in[7:0], gpr_data_s_in[15:8]}
		: gpr_data_s_in[15:0];
	// raw32 takes the low word unconverted; single-sourced values give undefined data there
	assign store_data = op_stfdx ? fpr_data_in
		: op_stfiwx ? {32'h0, fpr_data_in[31:0]}
		: is_fp ? {32'h0, single_word}
		: {48'h0, half_data};
	assign store_size = op_stfdx ? `FPHSU_SIZE_DOUBLE
		: is_fp ? `FPHSU_SIZE_WORD : `FPHSU_SIZE_HALF;
	// control
	fphsu_state_type state;
	fphsu_state_type next_state;
	wire logic take;
	wire logic take_good;
	wire logic accepted;
	// gate on the registered ready so the cycle right after reset refuses offers
	assign take = issue_ready_out && issue_valid_in;
	assign take_good = take && known && !is_invalid;
	assign accepted = state == fphsu_st_wait && mem_ready_in;
	always_comb
	begin
		next_state = state;
		unique case (state)
			fphsu_st_idle: if (take_good) next_state = fphsu_st_wait;
			fphsu_st_issue: next_state = fphsu_st_wait;
			fphsu_st_wait: if (mem_ready_in) next_state = fphsu_st_idle;
		endcase
	end
	// state and handshake flags
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state <= fphsu_st_idle;
			issue_ready_out <= 1'b0;
			mem_valid_out <= 1'b0;
			invalid_form_out <= 1'b0;
			unknown_instr_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			issue_ready_out <= next_state == fphsu_st_idle;
			mem_valid_out <= next_state == fphsu_st_wait;
			invalid_form_out <= take && known && is_invalid;
			unknown_instr_out <= take && !known;
		end
	end
	// request payload held for the whole wait
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			mem_addr_out <= 64'h0;
			mem_data_out <= 64'h0;
			mem_size_out <= 4'h0;
		end
		else if (take_good)
		begin
			mem_addr_out <= effective_address;
			mem_data_out <= store_data;
			mem_size_out <= store_size;
		end
	end
	// base write-back, issued once the store is taken by memory
	logic pend_update;
	logic [4:0] pend_base;
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			pend_update <= 1'b0;
			pend_base <= 5'h00;
			wb_valid_out <= 1'b0;
			wb_addr_out <= 5'h00;
			wb_data_out <= 64'h0;
		end
		else
		begin
			if (take_good)
			begin
				pend_update <= is_update;
				pend_base <= base_field;
			end
			wb_valid_out <= accepted && pend_update;
			if (accepted && pend_update)
			begin
				wb_addr_out <= pend_base;
				wb_data_out <= mem_addr_out;
			end
		end
	end
	a_wb_after_accept: assert property (@(posedge clk_in) disable iff (reset_in)
		wb_valid_out |-> $past(accepted) && $past(pend_update))
		else $error("write-back without accepted update store");
	a_wb_addr_match: assert property (@(posedge clk_in) disable iff (reset_in)
		wb_valid_out |-> wb_data_out == $past(mem_addr_out) && wb_addr_out != 5'h00)
		else $error("write-back value or base wrong");
	a_invalid_no_store: assert property (@(posedge clk_in) disable iff (reset_in)
		(take && is_update && base_field == 5'h00) |=> invalid_form_out && !mem_valid_out)
		else $error("invalid update form issued");
	a_zero_base: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && base_field == 5'h00) |=> mem_addr_out == $past(offset_value))
		else $error("zero base not substituted");
	a_dbl_data: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfdx) |=> mem_data_out == $past(fpr_data_in)
		&& mem_size_out == `FPHSU_SIZE_DOUBLE)
		else $error("double store data wrong");
	a_raw_word: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfiwx) |=> mem_data_out[31:0] == $past(fpr_data_in[31:0]))
		else $error("raw word altered");
	a_half_swap: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_sthbrx) |=> mem_data_out[15:8] == $past(gpr_data_s_in[7:0])
		&& mem_data_out[63:16] == 48'h0)
		else $error("byte reverse wrong");
	a_half_plain: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_sth) |=> mem_data_out == {48'h0, $past(gpr_data_s_in[15:0])}
		&& mem_size_out == `FPHSU_SIZE_HALF)
		else $error("half store data wrong");
	a_hold_request: assert property (@(posedge clk_in) disable iff (reset_in)
		(mem_valid_out && !mem_ready_in) |=> mem_valid_out && $stable(mem_addr_out))
		else $error("request dropped before accept");
	a_update_idx_addr: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_sthux) |=> mem_addr_out == $past(gpr_data_a_in + gpr_data_b_in))
		else $error("update indexed address wrong");
	a_disp_update: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && (op_sthu || op_stfsu)) |=> mem_addr_out
		== $past(gpr_data_a_in + fphsu_sign_extend(disp)))
		else $error("update displacement address wrong");
	a_single_conv: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && (op_stfsx || op_stfs || op_stfsux)) |=> mem_data_out
		== {32'h0, $past(single_word)} && mem_size_out == `FPHSU_SIZE_WORD)
		else $error("single store data wrong");
	// address forms with a live base, written from the register values themselves
	a_stfdx_addr: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfdx && base_field != 5'h00) |=> mem_addr_out
		== $past(gpr_data_a_in + gpr_data_b_in))
		else $error("double indexed address wrong");
	a_stfs_addr: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfs && base_field != 5'h00) |=> mem_addr_out
		== $past(gpr_data_a_in + fphsu_sign_extend(disp)))
		else $error("single displacement address wrong");
	a_stfsux_addr: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfsux) |=> mem_addr_out
		== $past(gpr_data_a_in + gpr_data_b_in))
		else $error("single update indexed address wrong");
	a_stfsx_addr: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfsx && base_field != 5'h00) |=> mem_addr_out
		== $past(gpr_data_a_in + gpr_data_b_in))
		else $error("single indexed address wrong");
	a_sth_addr: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_sth && base_field != 5'h00) |=> mem_addr_out
		== $past(gpr_data_a_in + fphsu_sign_extend(disp)))
		else $error("half displacement address wrong");
	// data formats: large exponents narrow by a plain bit pick, independent of the converter
	a_single_pick: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && is_fp && !op_stfdx && !op_stfiwx && fpr_data_in[62:52] > 11'h380)
		|=> mem_data_out == {32'h0, $past(fpr_data_in[63:62]), $past(fpr_data_in[58:29])})
		else $error("single narrowing wrong");
	a_raw_upper: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_stfiwx) |=> mem_data_out[63:32] == 32'h0
		&& mem_size_out == `FPHSU_SIZE_WORD)
		else $error("raw word size or padding wrong");
	a_half_low: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && op_sthbrx) |=> mem_data_out[7:0] == $past(gpr_data_s_in[15:8])
		&& mem_size_out == `FPHSU_SIZE_HALF)
		else $error("byte reverse low byte wrong");
	a_half_update: assert property (@(posedge clk_in) disable iff (reset_in)
		(take_good && (op_sthu || op_sthux)) |=> mem_data_out
		== {48'h0, $past(gpr_data_s_in[15:0])})
		else $error("half update data wrong");
	// refusals and write-back discipline
	a_unknown_flag: assert property (@(posedge clk_in) disable iff (reset_in)
		(take && !known) |=> unknown_instr_out && !mem_valid_out && !invalid_form_out)
		else $error("unknown word not refused");
	a_no_wb_plain: assert property (@(posedge clk_in) disable iff (reset_in)
		(accepted && !pend_update) |=> !wb_valid_out)
		else $error("write-back from a plain store");
	a_wb_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
		wb_valid_out |=> !wb_valid_out)
		else $error("write-back longer than one cycle");
endmodule : fphsu_store_unit
`default_nettype wire

// ---- testbench/fphsu_mem_model.sv ----
// memory side model: accepts each store request after a random stall
// assumes the bench seeds $urandom before any traffic
`timescale 1ns/1ns
`default_nettype none
module fphsu_mem_model (
	input wire logic clk_in, // core clock
	input wire logic reset_in, // synchronous reset, high
	input wire logic mem_valid_in, // store request from the unit
	output var logic mem_ready_out // accept, high for one edge
);
	int wait_left = 0;
	// stall 0..3 cycles so prompt and slow answers both occur
	initial
		mem_ready_out = 1'b0;
	always @(posedge clk_in)
	begin
		#1;
		if (reset_in || !mem_valid_in || mem_ready_out)
		begin
			mem_ready_out = 1'b0; // ready never shows without a request
			wait_left = $urandom % 4;
		end
		else if (wait_left == 0)
			mem_ready_out = 1'b1;
		else
			wait_left = wait_left - 1;
	end
endmodule : fphsu_mem_model
`default_nettype wire

// ---- testbench/fp_and_halfword_store_unit_bench.sv ----
// bench for the fp and half-word store unit, random fields and corner cases
// assumes register files answer combinationally from bench arrays
`timescale 1ns/1ns
`default_nettype none
module fp_and_halfword_store_unit_bench;
	logic clk_in = 1'b0, reset_in = 1'b1, issue_valid_in = 1'b0, issue_ready_out;
	logic [31:0] instr_in = 32'h0;
	logic [4:0] gpr_addr_a_out, gpr_addr_b_out, gpr_addr_s_out, fpr_addr_out, wb_addr_out;
	logic [63:0] mem_addr_out, mem_data_out, wb_data_out;
	logic [3:0] mem_size_out;
	logic mem_valid_out, mem_ready_in, wb_valid_out, invalid_form_out, unknown_instr_out;
	logic [63:0] gpr [0:31];
	logic [63:0] fpr [0:31];
	int fail_count = 0;
	int num_checks = 0;
	localparam logic [31:0] PAT [0:10] = '{32'h7C0005AE, 32'h7C0007AE, 32'hD0000000,
		32'hD4000000, 32'h7C00056E, 32'h7C00052E, 32'hB0000000, 32'h7C00072C,
		32'hB4000000, 32'h7C00036E, 32'h7C00002E};
	always #10 clk_in = ~clk_in;
	fphsu_store_unit fphsu_store_unit_i (.clk_in(clk_in), .reset_in(reset_in),
		.issue_valid_in(issue_valid_in), .instr_in(instr_in), .issue_ready_out(issue_ready_out),
		.gpr_addr_a_out(gpr_addr_a_out), .gpr_data_a_in(gpr[gpr_addr_a_out]),
		.gpr_addr_b_out(gpr_addr_b_out), .gpr_data_b_in(gpr[gpr_addr_b_out]),
		.gpr_addr_s_out(gpr_addr_s_out), .gpr_data_s_in(gpr[gpr_addr_s_out]),
		.fpr_addr_out(fpr_addr_out), .fpr_data_in(fpr[fpr_addr_out]),
		.mem_valid_out(mem_valid_out), .mem_ready_in(mem_ready_in), .mem_addr_out(mem_addr_out),
		.mem_data_out(mem_data_out), .mem_size_out(mem_size_out), .wb_valid_out(wb_valid_out),
		.wb_addr_out(wb_addr_out), .wb_data_out(wb_data_out),
		.invalid_form_out(invalid_form_out), .unknown_instr_out(unknown_instr_out));
	fphsu_mem_model fphsu_mem_model_i (.clk_in(clk_in), .reset_in(reset_in),
		.mem_valid_in(mem_valid_out), .mem_ready_out(mem_ready_in));
	// compare tasks, one per result width
	task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk64
	task automatic chk1(input logic got, input logic exp);
		chk64({63'h0, got}, {63'h0, exp});
	endtask : chk1
	// expected single word: bit pick for large or zero exponents, shifted fraction for other small ones
	function automatic logic [31:0] exp_single(input logic [63:0] f);
		logic [52:0] frac;
		int e;
		frac = {1'b1, f[51:0]};
		e = int'(f[62:52]) - 1023;
		if (f[62:52] > 11'h380 || f[62:52] == 11'h000)
			return {f[63:62], f[58:29]};
		while (e < -126)
		begin
			frac = frac >> 1;
			e++;
		end
		return {f[63], 8'h00, frac[51:29]};
	endfunction : exp_single
	// stored data per kind; single stores expect single-format operands
	function automatic logic [63:0] exp_data(input int k, input logic [4:0] src_idx);
		logic [63:0] f;
		logic [63:0] g;
		f = fpr[src_idx];
		g = gpr[src_idx];
		case (k)
			0: exp_data = f;
			1: exp_data = {32'h0, f[31:0]};
			7: exp_data = {48'h0, g[7:0], g[15:8]};
			6, 8, 9: exp_data = {48'h0, g[15:0]};
			default: exp_data = {32'h0, exp_single(f)};
		endcase
	endfunction : exp_data
	// instruction of kind k with source, base and low (index or displacement) fields
	function automatic logic [31:0] build(input int k, input logic [4:0] src,
		input logic [4:0] base, input logic [15:0] low);
		build = PAT[k];
		build[25:21] = src;
		build[20:16] = base;
		if (PAT[k][31:26] == 6'h1F)
			build[15:11] = low[4:0];
		else
			build[15:0] = low;
	endfunction : build
	// one instruction through issue, memory handshake and writeback
	task automatic run(input int k, input logic [31:0] ins);
		logic upd;
		logic bad;
		logic [4:0] base_idx;
		logic [63:0] eff_addr;
		logic [63:0] mask;
		int t;
		base_idx = ins[20:16];
		upd = k == 3 || k == 4 || k == 8 || k == 9;
		bad = k > 9 || (upd && base_idx == 5'h0);
		eff_addr = ((base_idx == 5'h0 && !upd) ? 64'h0 : gpr[base_idx])
			+ ((ins[31:26] == 6'h1F) ? gpr[ins[15:11]] : {{48{ins[15]}}, ins[15:0]});
		mask = (k == 0) ? 64'hFFFFFFFFFFFFFFFF : (k < 6) ? 64'hFFFFFFFF : 64'hFFFF;
		t = 0;
		while (issue_ready_out !== 1'b1 && t < 20)
		begin
			@(posedge clk_in);
			#1;
			t++;
		end
		chk1(issue_ready_out, 1'b1);
		issue_valid_in = 1'b1;
		instr_in = ins;
		@(posedge clk_in);
		#1;
		issue_valid_in = 1'b0;
		instr_in = $urandom; // junk while idle must be ignored
		chk1(issue_ready_out, bad);
		chk1(mem_valid_out, !bad);
		chk1(invalid_form_out, bad && k <= 9);
		chk1(unknown_instr_out, k > 9);
		if (!bad)
		begin
			chk64(mem_addr_out, eff_addr);
			chk64(mem_data_out & mask, exp_data(k, ins[25:21]) & mask);
			chk64({60'h0, mem_size_out}, (k == 0) ? 64'h8 : (k < 6) ? 64'h4 : 64'h2);
			t = 0;
			do
			begin
				@(posedge clk_in);
				t++;
			end
			while (mem_ready_in !== 1'b1 && t < 20);
			#1;
			chk1(t < 20, 1'b1);
			chk1(wb_valid_out, upd);
			if (upd)
			begin
				chk64({59'h0, wb_addr_out}, {59'h0, base_idx});
				chk64(wb_data_out, eff_addr);
			end
		end
	endtask : run
	// verdict, the only place that ends the run
	task automatic close_out;
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// watchdog: the tests need a few thousand cycles, so 20000 means a hang
	initial
	begin
		#400000;
		fail_count++;
		close_out();
	end
	// register contents fixed by the seed, then corners, a mid-run reset and random traffic
	initial
	begin
		int kind;
		void'($urandom(5047));
		for (int i = 0; i < 32; i++)
		begin
			gpr[i] = {$urandom, $urandom};
			fpr[i] = {$urandom, $urandom};
			if (i % 4 == 3)
				fpr[i][62:52] = 11'h36A + 11'($urandom % 23);
			else
				fpr[i][62:52] = 11'h381 + 11'($urandom % 254);
		end
		fpr[0] = 64'h0;
		repeat (6) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		chk1(issue_ready_out, 1'b0);
		chk1(mem_valid_out, 1'b0);
		// base field zero: plain forms add nothing, update forms are refused
		for (int k = 0; k < 11; k++)
			run(k, build(k, 5'(k), 5'h00, 16'h8001));
		// live base with a negative displacement or a high index
		for (int k = 0; k < 11; k++)
			run(k, build(k, 5'(k + 11), 5'(k + 1), 16'hFFF0));
		// mid-run reset: outputs clear, the unit comes back idle
		reset_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		chk1(issue_ready_out, 1'b0);
		chk1(mem_valid_out, 1'b0);
		chk1(wb_valid_out, 1'b0);
		repeat (400)
		begin
			kind = int'($urandom % 11);
			run(kind, build(kind, 5'($urandom), 5'($urandom), 16'($urandom)));
		end
		close_out();
	end
endmodule : fp_and_halfword_store_unit_bench
`default_nettype wire
